// File: hw/ics_bus_cond.sv
// finds clock edges and start / stop conditions on the synchronised bus lines
// assumes scl and sda have already passed the synchroniser; outputs are one-cycle pulses
module ics_bus_cond (
    input wire logic clk_in,   // system clock
    input wire logic rst_in,   // async reset, active high
    input wire logic scl_in,   // synchronised bus clock
    input wire logic sda_in,   // synchronised bus data
    output logic scl_rise_out, // bus clock rose
    output logic scl_fall_out, // bus clock fell
    output logic start_out,    // start or repeated start
    output logic stop_out      // stop
);
    logic scl_d_reg;
    logic sda_d_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_in;
            sda_d_reg <= sda_in;
        end
    end

    assign scl_rise_out = scl_in & ~scl_d_reg;
    assign scl_fall_out = ~scl_in & scl_d_reg;
    // data moving while the clock stays high marks a bus condition
    assign start_out = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    assign stop_out = scl_in & scl_d_reg & ~sda_d_reg & sda_in;

endmodule : ics_bus_cond

// File: hw/ics_i2c_slave.sv
// i2c slave port giving an outside master access to the configuration registers
// assumes the register file sits on clk_in, answers reg_rd_data_in combinationally
// for reg_addr_out, ignores writes to addresses it lacks, and that the pad ties
// sda low while sda_oe_out is high.
// Summary of operation
// - slave only, 7-bit address, up to 400 kbit/s
// - never stretches clock; master uses listed transfers only
// - upper three address bits fixed at 001
// - two three-level pins give lower four bits
// - last address bit: 0 write, 1 read
// - bytes after register address are acknowledged write data
// - writes to missing registers dropped silently
// - device sends bytes while master keeps acknowledging
// - reads of missing registers return anything
// - write, read, soft reset, address commands supported
// - general-call reset acts like power-up reset
// - soft reset also restores all trimming values
// - select pins latched at power-up set address
// - bus command re-samples the select pins
// - write takes effect on last data bit's falling clock
module ics_i2c_slave
    import ics_pkg::*;
(
    input wire logic clk_in,                     // 250 MHz system clock
    input wire logic rst_in,                     // async power-up reset, active high
    input wire logic scl_in,                     // bus clock pin
    input wire logic sda_in,                     // bus data pin level
    output logic sda_out,                        // bus data drive value, always low
    output logic sda_oe_out,                     // bus data pulled low when high
    input wire logic [1:0] addr_sel_high_pin_in, // high select pin level code
    input wire logic [1:0] addr_sel_low_pin_in,  // low select pin level code
    output logic [7:0] reg_addr_out,             // register pointer for reads
    input wire logic [7:0] reg_rd_data_in,       // read data for reg_addr_out
    output logic reg_wr_valid_out,               // one-cycle write strobe
    output ics_pkg::ics_wr_s reg_wr_out,         // write address and data
    output logic soft_reset_out,                 // one-cycle reset to config and trim logic
    output logic [6:0] slave_addr_out            // current 7-bit slave address
);
    import ics_pkg::*;

    logic [1:0] bus_s;
    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    ics_sync #(.WIDTH(2)) u_bus_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({scl_in, sda_in}),
        .sync_out(bus_s)
    );

    ics_sync #(.WIDTH(4)) u_pin_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({addr_sel_high_pin_in, addr_sel_low_pin_in}),
        .sync_out(pins_s)
    );

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    ics_bus_cond u_cond (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .scl_in(scl_s),
        .sda_in(sda_s),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(start_det),
        .stop_out(stop_det)
    );

    ics_state_e st_reg, st_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic ack_ph_reg, ack_ph_next;
    logic oe_reg, oe_next;
    logic mack_reg, mack_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [1:0] gc_act_reg, gc_act_next;
    logic [3:0] lsb_reg, lsb_next;
    logic [1:0] samp_cnt_reg, samp_cnt_next;
    logic wr_valid_reg, wr_valid_next;
    ics_wr_s wr_reg, wr_next;
    logic srst_reg, srst_next;
    logic [6:0] my_addr;

    assign my_addr = {ICS_ADDR_MSB, lsb_reg};

    always_comb begin
        st_next = st_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        ack_ph_next = ack_ph_reg;
        oe_next = oe_reg;
        mack_next = mack_reg;
        ptr_next = ptr_reg;
        gc_act_next = gc_act_reg;
        lsb_next = lsb_reg;
        samp_cnt_next = samp_cnt_reg;
        wr_valid_next = 1'b0;
        wr_next = wr_reg;
        srst_next = 1'b0;

        // address capture waits for the pin synchroniser to settle
        if (samp_cnt_reg != 2'h0) begin
            samp_cnt_next = samp_cnt_reg - 2'h1;
            if (samp_cnt_reg == 2'h1) begin
                lsb_next = {ics_tern_bits(pins_s[3:2]), ics_tern_bits(pins_s[1:0])};
            end
        end

        if (stop_det) begin
            st_next = ICS_ST_IDLE;
            oe_next = 1'b0;
            ack_ph_next = 1'b0;
            gc_act_next = ICS_GC_NONE;
        end else if (start_det) begin
            // a repeated start keeps the pointer so a read follows the written address
            st_next = ICS_ST_DEVADR;
            bit_cnt_next = 4'h0;
            ack_ph_next = 1'b0;
            oe_next = 1'b0;
            gc_act_next = ICS_GC_NONE;
        end else if (st_reg != ICS_ST_IDLE && st_reg != ICS_ST_IGNORE) begin
            if (scl_rise) begin
                if (ack_ph_reg) begin
                    mack_next = ~sda_s;
                end else begin
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                    if (st_reg != ICS_ST_RDATA) begin
                        shift_next = {shift_reg[6:0], sda_s};
                    end
                end
            end else if (scl_fall) begin
                if (ack_ph_reg) begin
                    // end of the acknowledge slot
                    ack_ph_next = 1'b0;
                    bit_cnt_next = 4'h0;
                    oe_next = 1'b0;
                    if (st_reg == ICS_ST_RDATA) begin
                        if (mack_reg) begin
                            shift_next = reg_rd_data_in;
                            oe_next = ~reg_rd_data_in[7];
                            ptr_next = ptr_reg + 8'h1;
                        end else begin
                            // nack ends the read; only stop or start wake us
                            st_next = ICS_ST_IGNORE;
                        end
                    end
                    if (gc_act_reg == ICS_GC_SRST) begin
                        srst_next = 1'b1;
                        st_next = ICS_ST_IDLE;
                        ptr_next = ICS_PTR_RST;
                        samp_cnt_next = ICS_SAMP_DLY;
                    end else if (gc_act_reg == ICS_GC_RESAMPLE) begin
                        samp_cnt_next = ICS_SAMP_DLY;
                    end
                    gc_act_next = ICS_GC_NONE;
                end else if (bit_cnt_reg == ICS_BYTE_BITS) begin
                    ack_ph_next = 1'b1;
                    case (st_reg)
                        ICS_ST_DEVADR: begin
                            if (shift_reg[7:1] == my_addr) begin
                                oe_next = 1'b1;
                                mack_next = 1'b1;
                                st_next = shift_reg[0] ? ICS_ST_RDATA : ICS_ST_REGADR;
                            end else if (shift_reg == ICS_GCALL_ADDR) begin
                                oe_next = 1'b1;
                                st_next = ICS_ST_GCALL;
                            end else begin
                                st_next = ICS_ST_IGNORE;
                            end
                        end
                        ICS_ST_REGADR: begin
                            ptr_next = shift_reg;
                            oe_next = 1'b1;
                            st_next = ICS_ST_WDATA;
                        end
                        ICS_ST_WDATA: begin
                            // every byte is taken; absent registers drop it outside
                            wr_valid_next = 1'b1;
                            wr_next.addr = ptr_reg;
                            wr_next.data = shift_reg;
                            ptr_next = ptr_reg + 8'h1;
                            oe_next = 1'b1;
                        end
                        ICS_ST_GCALL: begin
                            if (shift_reg == ICS_CMD_SRST) begin
                                gc_act_next = ICS_GC_SRST;
                                oe_next = 1'b1;
                            end else if (shift_reg == ICS_CMD_RESAMPLE) begin
                                gc_act_next = ICS_GC_RESAMPLE;
                                oe_next = 1'b1;
                            end else begin
                                st_next = ICS_ST_IGNORE;
                            end
                        end
                        ICS_ST_RDATA: begin
                            oe_next = 1'b0; // release for the master's answer
                        end
                        default: begin
                            st_next = ICS_ST_IGNORE;
                        end
                    endcase
                end else if (st_reg == ICS_ST_RDATA) begin
                    // data changes only while the clock is low; we never hold the clock
                    shift_next = {shift_reg[6:0], 1'b0};
                    oe_next = ~shift_reg[6];
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= ICS_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_ph_reg <= 1'b0;
            oe_reg <= 1'b0;
            mack_reg <= 1'b0;
            ptr_reg <= ICS_PTR_RST;
            gc_act_reg <= ICS_GC_NONE;
            lsb_reg <= ICS_LSB_RST;
            samp_cnt_reg <= ICS_SAMP_DLY;
            wr_valid_reg <= 1'b0;
            wr_reg <= '0;
            srst_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ack_ph_reg <= ack_ph_next;
            oe_reg <= oe_next;
            mack_reg <= mack_next;
            ptr_reg <= ptr_next;
            gc_act_reg <= gc_act_next;
            lsb_reg <= lsb_next;
            samp_cnt_reg <= samp_cnt_next;
            wr_valid_reg <= wr_valid_next;
            wr_reg <= wr_next;
            srst_reg <= srst_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_reg;
    assign reg_addr_out = ptr_reg;
    assign reg_wr_valid_out = wr_valid_reg;
    assign reg_wr_out = wr_reg;
    assign soft_reset_out = srst_reg;
    assign slave_addr_out = my_addr;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sda_edge_a: assert property ($rose(sda_oe_out) |-> $past(scl_fall))
        else $error("sda drive began outside a clock-low phase");

    addr_match_a: assert property (
        (st_reg == ICS_ST_DEVADR && scl_fall && !ack_ph_reg && bit_cnt_reg == ICS_BYTE_BITS
         && shift_reg[7:1] != my_addr && shift_reg != ICS_GCALL_ADDR) |=> !sda_oe_out)
        else $error("acknowledged a foreign address");

    pin_map_a: assert property (
        (samp_cnt_reg == 2'h1) |=>
        slave_addr_out[3:0] == {ics_tern_bits($past(pins_s[3:2])), ics_tern_bits($past(pins_s[1:0]))})
        else $error("select pins mapped to wrong address bits");

    dir_sel_a: assert property (
        (st_reg == ICS_ST_DEVADR && scl_fall && !ack_ph_reg && bit_cnt_reg == ICS_BYTE_BITS
         && shift_reg[7:1] == my_addr) |=>
        (st_reg == ($past(shift_reg[0]) ? ICS_ST_RDATA : ICS_ST_REGADR)) && sda_oe_out)
        else $error("direction bit not honoured");

    wr_ack_a: assert property (reg_wr_valid_out |-> sda_oe_out && ack_ph_reg)
        else $error("write byte not acknowledged");

    ptr_step_a: assert property (reg_wr_valid_out |-> ptr_reg == reg_wr_out.addr + 8'h1)
        else $error("pointer did not advance after write");

    rd_load_a: assert property (
        (st_reg == ICS_ST_RDATA && ack_ph_reg && mack_reg && scl_fall && !stop_det && !start_det)
        |=> shift_reg == $past(reg_rd_data_in) ##1 !scl_fall [*2])
        else $error("read byte not loaded");

    srst_seq_a: assert property (
        $rose(soft_reset_out) |-> st_reg == ICS_ST_IDLE && samp_cnt_reg == ICS_SAMP_DLY
        ##3 samp_cnt_reg == 2'h0)
        else $error("soft reset did not restart address sampling");

    resample_a: assert property (
        (gc_act_reg == ICS_GC_RESAMPLE && ack_ph_reg && scl_fall && !stop_det && !start_det)
        |=> samp_cnt_reg == ICS_SAMP_DLY)
        else $error("resample command ignored");

    commit_a: assert property ($rose(reg_wr_valid_out) |-> $past(scl_fall) ##1 !reg_wr_valid_out)
        else $error("write strobe not tied to falling clock");

endmodule : ics_i2c_slave

// File: hw/ics_pkg.sv
// constants, types and helper functions for the i2c configuration slave
// assumes one 250 MHz system clock; the bus clock is only sampled, never used as a clock
package ics_pkg;

    // bus rate ceiling the sampler is sized for, and the system clock rate
    localparam int ICS_BUS_MAX_KBPS = 400;
    localparam int ICS_CLK_MHZ = 250;

    // fixed upper part of the 7-bit slave address
    localparam logic [2:0] ICS_ADDR_MSB = 3'h1;

    // general-call address byte and the two command bytes that follow it
    localparam logic [7:0] ICS_GCALL_ADDR = 8'h00;
    localparam logic [7:0] ICS_CMD_SRST = 8'h06;
    localparam logic [7:0] ICS_CMD_RESAMPLE = 8'h04;

    // bits in one byte before the acknowledge slot
    localparam logic [3:0] ICS_BYTE_BITS = 4'h8;

    // cycles between a sampling request and the capture of the select pins;
    // covers the two-stage synchroniser on the pin inputs
    localparam logic [1:0] ICS_SAMP_DLY = 2'h3;

    // reset values
    localparam logic [7:0] ICS_PTR_RST = 8'h00;
    localparam logic [3:0] ICS_LSB_RST = 4'h0;

    // three-level select pin codes, as delivered by the pin comparators
    localparam logic [1:0] ICS_LVL_LOW = 2'h0;
    localparam logic [1:0] ICS_LVL_MID = 2'h1;
    localparam logic [1:0] ICS_LVL_HIGH = 2'h2;

    // pending general-call actions
    localparam logic [1:0] ICS_GC_NONE = 2'h0;
    localparam logic [1:0] ICS_GC_SRST = 2'h1;
    localparam logic [1:0] ICS_GC_RESAMPLE = 2'h2;

    typedef enum logic [6:0] {
        ICS_ST_IDLE = 7'h01,
        ICS_ST_DEVADR = 7'h02,
        ICS_ST_REGADR = 7'h04,
        ICS_ST_WDATA = 7'h08,
        ICS_ST_RDATA = 7'h10,
        ICS_ST_GCALL = 7'h20,
        ICS_ST_IGNORE = 7'h40
    } ics_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } ics_wr_s;

    // one select pin level to two address bits: low 00, mid 01, high 11
    function automatic logic [1:0] ics_tern_bits(input logic [1:0] lvl);
        case (lvl)
            ICS_LVL_MID: ics_tern_bits = 2'h1;
            ICS_LVL_HIGH: ics_tern_bits = 2'h3;
            default: ics_tern_bits = 2'h0;
        endcase
    endfunction : ics_tern_bits

endpackage : ics_pkg

// File: hw/ics_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
// assumes the inputs are levels that stay put for several clock periods
module ics_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,               // system clock
    input wire logic rst_in,               // async reset, active high
    input wire logic [WIDTH-1:0] async_in, // asynchronous levels
    output logic [WIDTH-1:0] sync_out      // synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : ics_sync

// File: tb/ics_tb_master.sv
// behavioural bus master for the i2c configuration slave bench
// assumes the bench resolves sda with a pull-up; scl idles high between frames
module ics_tb_master (
    input wire logic clk_in, // bench clock, paces every bus phase
    input wire logic sda_in, // resolved data line
    output logic scl_out,    // bus clock drive
    output logic sda_out     // data drive, 1 releases the line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // a quarter bit is 3 clocks, so one bit lasts 48 ns
    task automatic quarter();
        repeat (3) @(posedge clk_in);
    endtask : quarter

    // never waits on scl: no clock stretching is relied upon
    task automatic bit_cycle(input logic drive, output logic seen);
        sda_out <= drive;
        quarter();
        scl_out <= 1'b1;
        quarter();
        seen = sda_in;
        quarter();
        scl_out <= 1'b0;
        quarter();
    endtask : bit_cycle

    task automatic start_cond();
        sda_out <= 1'b1;
        quarter();
        scl_out <= 1'b1;
        quarter();
        sda_out <= 1'b0;
        quarter();
        scl_out <= 1'b0;
        quarter();
    endtask : start_cond

    task automatic stop_cond();
        sda_out <= 1'b0;
        quarter();
        scl_out <= 1'b1;
        quarter();
        sda_out <= 1'b1;
        quarter();
    endtask : stop_cond

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], dummy);
        end
        bit_cycle(1'b1, ack);
    endtask : write_byte

    // the last byte of a read is answered with nack before stop
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(nack, dummy);
    endtask : read_byte
endmodule : ics_tb_master

// File: tb/tb.sv
// self-checking bench for the i2c configuration slave
// assumes ics_tb_master drives the bus and a byte array here acts as register file
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ics_pkg::*;

    logic clk, rst, scl, m_sda, sda, wr_valid, srst, sda_drv, sda_oe;
    logic [1:0] pin_hi, pin_lo;
    logic [7:0] reg_addr, rd_data;
    logic [6:0] slave_addr, cur_addr;
    ics_wr_s wr;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    logic [15:0] wr_q [$];
    int n_errors, total_checks, n_srst, n_wr, cycles;

    assign sda = sda_oe ? 1'b0 : m_sda; // pull-up unless someone pulls low
    assign rd_data = mem[reg_addr];

    ics_i2c_slave i_dut (
        .clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .addr_sel_high_pin_in(pin_hi), .addr_sel_low_pin_in(pin_lo),
        .reg_addr_out(reg_addr), .reg_rd_data_in(rd_data),
        .reg_wr_valid_out(wr_valid), .reg_wr_out(wr),
        .soft_reset_out(srst), .slave_addr_out(slave_addr)
    );

    ics_tb_master i_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        if (srst === 1'b1) n_srst++;
        if (wr_valid === 1'b1) begin
            n_wr++;
            mem[wr.addr] = wr.data;
            if (wr_q.size() == 0) check("spare write", 16'h0001, 16'h0000);
            else check("write strobe", wr, wr_q.pop_front());
        end
    end

    // the whole run needs about 20000 to 26000 cycles, depending on the random burst lengths
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            conclude();
        end
    end

    function automatic logic [1:0] lvl_bits(input logic [1:0] l);
        return (l == 2'h1) ? 2'h1 : (l == 2'h2) ? 2'h3 : 2'h0;
    endfunction : lvl_bits

    function automatic logic [6:0] addr_of(input logic [1:0] h, input logic [1:0] l);
        return {3'h1, lvl_bits(h), lvl_bits(l)};
    endfunction : addr_of

    task automatic open_xfer(input logic [6:0] a, input logic rd, input logic exp_ack);
        logic ack;
        i_master.start_cond();
        i_master.write_byte({a, rd}, ack);
        check("address ack", 16'(ack), 16'(exp_ack));
    endtask : open_xfer

    task automatic point_at(input logic [7:0] ra);
        logic ack;
        open_xfer(cur_addr, 1'b0, 1'b0);
        i_master.write_byte(ra, ack);
        check("register address ack", 16'(ack), 16'h0000);
    endtask : point_at

    task automatic write_burst(input logic [7:0] ra, input int n);
        logic ack;
        logic [7:0] d;
        point_at(ra);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            exp_mem[8'(ra + i)] = d;
            wr_q.push_back({8'(ra + i), d});
            i_master.write_byte(d, ack);
            check("data ack", 16'(ack), 16'h0000);
            check("write landed", 16'(wr_q.size()), 16'h0000);
        end
        i_master.stop_cond();
    endtask : write_burst

    task automatic read_burst(input logic [7:0] ra, input int n);
        logic [7:0] d;
        point_at(ra);
        open_xfer(cur_addr, 1'b1, 1'b0); // repeated start
        for (int i = 0; i < n; i++) begin
            i_master.read_byte(logic'(i == n - 1), d);
            check("read data", 16'(d), 16'(exp_mem[8'(ra + i)]));
        end
        i_master.stop_cond();
    endtask : read_burst

    task automatic gcall(input logic [7:0] cmd, input logic exp_ack);
        logic ack;
        open_xfer(7'h00, 1'b0, 1'b0);
        i_master.write_byte(cmd, ack);
        check("command ack", 16'(ack), 16'(exp_ack));
        i_master.stop_cond();
    endtask : gcall

    initial begin
        logic ack;
        logic [7:0] ra;
        logic [7:0] d;
        int n;
        rst = 1'b1;
        pin_hi = 2'h1;
        pin_lo = 2'h2;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
            exp_mem[i] = 8'(i) ^ 8'ha5;
        end
        void'($urandom(32'h5a5858f6));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        cur_addr = addr_of(pin_hi, pin_lo);
        check("power-up address", 16'(slave_addr), 16'(cur_addr));
        check("idle drive", {14'h0, sda_drv, sda_oe}, 16'h0000);
        // a foreign address must leave the bus and the registers alone
        open_xfer(cur_addr ^ 7'h01, 1'b0, 1'b1);
        i_master.write_byte(8'h00, ack);
        check("foreign byte ack", 16'(ack), 16'h0001);
        i_master.stop_cond();
        check("foreign writes", 16'(n_wr), 16'h0000);
        // fixed upper bits differ: the device must stay off the bus
        open_xfer(cur_addr ^ 7'h20, 1'b1, 1'b1);
        i_master.stop_cond();
        write_burst(8'h02, 1);
        write_burst(8'hfd, 3);
        for (int k = 0; k < 6; k++) begin
            ra = 8'($urandom);
            n = 1 + $urandom_range(5);
            write_burst(ra, n);
            read_burst(ra, n);
        end
        read_burst(8'hfd, 3);
        read_burst(8'h02, 1);
        // level code 3 is taken as low
        for (int h = 0; h < 4; h++) begin
            for (int l = 0; l < 4; l++) begin
                @(posedge clk);
                pin_hi <= 2'(h);
                pin_lo <= 2'(l);
                gcall(ICS_CMD_RESAMPLE, 1'b0);
                repeat (10) @(posedge clk);
                cur_addr = addr_of(2'(h), 2'(l));
                check("resampled address", 16'(slave_addr), 16'(cur_addr));
                read_burst(8'(h * 4 + l), 1);
            end
        end
        gcall(8'h07, 1'b1);
        check("reset on refusal", 16'(n_srst), 16'h0000);
        @(posedge clk);
        pin_hi <= 2'h2;
        pin_lo <= 2'h0;
        write_burst(8'h40, 2);
        gcall(ICS_CMD_SRST, 1'b0);
        repeat (10) @(posedge clk);
        check("reset pulses", 16'(n_srst), 16'h0001);
        check("pointer after reset", 16'(reg_addr), 16'(ICS_PTR_RST));
        cur_addr = addr_of(2'h2, 2'h0);
        check("address after reset", 16'(slave_addr), 16'(cur_addr));
        open_xfer(cur_addr, 1'b1, 1'b0);
        i_master.read_byte(1'b1, d);
        i_master.stop_cond();
        check("read after reset", 16'(d), 16'(exp_mem[8'h00]));
        conclude();
    end
endmodule : tb
